/* gpa_core.sv */
// Gain, prescaler, limit registers and limit compare for a 4-channel readout
//
// How it works
// - One gain field drives all channels
// - Gain codes select 1x, 4x, 16x, 64x
// - Prescaler field right-shifts the selected channel count
// - Codes 000-110 divide by 1 to 64
// - Each limit is upper byte over lower
// - Interrupt when result at or below low
// - Interrupt when result above high limit
// - Low limit bytes at 08h and 09h
// - High limit bytes at 0Ah and 0Bh
// - Limit bytes reset to zero
// - Send Byte with MSB set loads pointer
// - Selection picks green, red, blue, clear
`timescale 1ns/100ps
module gpa_core
   import gpa_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        wr_valid_in,
   input  wire logic        wr_first_in,
   input  wire logic [7:0]  wr_data_in,
   input  wire logic        rd_req_in,
   output logic      [7:0]  rd_data_out,
   output logic             rd_valid_out,
   input  wire gpa_counts_t count_in,
   input  wire logic        conv_done_in,
   output logic      [1:0]  gain_sel_out,
   output logic      [6:0]  gain_factor_out,
   output logic      [15:0] scaled_out,
   output logic             int_out
);
   gpa_wr_state_t wr_state;
   logic [4:0]    ptr;
   logic [7:0]    gain_reg;
   logic [7:0]    source_reg;
   gpa_limit_t    low_limit;
   gpa_limit_t    high_limit;
   logic [15:0]   next_scaled;
   logic          data_wr;
   logic          cmd_wr;

   function automatic logic [6:0] gain_factor(input logic [1:0] code);
      case (code)
         GPA_GAIN_1X:  gain_factor = GPA_FACTOR_1;
         GPA_GAIN_4X:  gain_factor = GPA_FACTOR_4;
         GPA_GAIN_16X: gain_factor = GPA_FACTOR_16;
         default:      gain_factor = GPA_FACTOR_64;
      endcase
   endfunction

   function automatic logic [15:0] pick(input gpa_counts_t c,
                                        input logic [1:0]  s);
      case (s)
         GPA_SRC_GREEN: pick = c.green;
         GPA_SRC_RED:   pick = c.red;
         GPA_SRC_BLUE:  pick = c.blue;
         default:       pick = c.clear;
      endcase
   endfunction

   function automatic logic [7:0] reg_read(input logic [4:0] a,
                                           input logic [7:0] g,
                                           input logic [7:0] s,
                                           input gpa_limit_t lo,
                                           input gpa_limit_t hi);
      case (a)
         GPA_OFS_INT_SOURCE: reg_read = s;
         GPA_OFS_GAIN:       reg_read = g;
         GPA_OFS_LOW_LOWER:  reg_read = lo.lower;
         GPA_OFS_LOW_UPPER:  reg_read = lo.upper;
         GPA_OFS_HIGH_LOWER: reg_read = hi.lower;
         GPA_OFS_HIGH_UPPER: reg_read = hi.upper;
         default:            reg_read = 8'h00;
      endcase
   endfunction

   // First byte with MSB set is a command; later bytes are data
   assign cmd_wr  = wr_valid_in && wr_first_in && wr_data_in[GPA_CMD_BIT];
   assign data_wr = wr_valid_in && !wr_first_in && (wr_state == GPA_ST_DATA);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_state <= GPA_ST_IDLE;
      end else if (wr_valid_in && wr_first_in) begin
         wr_state <= cmd_wr ? GPA_ST_DATA : GPA_ST_IDLE;
      end
   end

   // Pointer: loaded by command, advances on each data byte or read
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ptr <= GPA_RST_PTR;
      end else if (cmd_wr) begin
         ptr <= wr_data_in[GPA_ADDR_MSB:0];
      end else if (data_wr || rd_req_in) begin
         ptr <= ptr + 5'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         gain_reg   <= GPA_RST_GAIN;
         source_reg <= GPA_RST_SOURCE;
      end else if (data_wr) begin
         case (ptr)
            GPA_OFS_GAIN:       gain_reg   <= wr_data_in & GPA_GAIN_MASK;
            GPA_OFS_INT_SOURCE: source_reg <= wr_data_in & GPA_SOURCE_MASK;
            default:            ;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         low_limit  <= {GPA_RST_LIMIT, GPA_RST_LIMIT};
         high_limit <= {GPA_RST_LIMIT, GPA_RST_LIMIT};
      end else if (data_wr) begin
         case (ptr)
            GPA_OFS_LOW_LOWER:  low_limit.lower  <= wr_data_in;
            GPA_OFS_LOW_UPPER:  low_limit.upper  <= wr_data_in;
            GPA_OFS_HIGH_LOWER: high_limit.lower <= wr_data_in;
            GPA_OFS_HIGH_UPPER: high_limit.upper <= wr_data_in;
            default:            ;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_out  <= 8'h00;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_req_in;
         if (rd_req_in) begin
            rd_data_out <= reg_read(ptr, gain_reg, source_reg,
                                    low_limit, high_limit);
         end
      end
   end

   // Common gain to the analog front end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         gain_sel_out    <= GPA_GAIN_1X;
         gain_factor_out <= GPA_FACTOR_1;
      end else begin
         gain_sel_out    <= gain_reg[GPA_GAIN_MSB:GPA_GAIN_LSB];
         gain_factor_out <= gain_factor(
                               gain_reg[GPA_GAIN_MSB:GPA_GAIN_LSB]);
      end
   end

   // Divide by a power of two; code 111 is left to shift by seven
   assign next_scaled = pick(count_in, source_reg[GPA_SOURCE_MSB:0]) >>
                        gain_reg[GPA_PRESCALE_MSB:0];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         scaled_out <= 16'h0000;
         int_out    <= 1'b0;
      end else if (conv_done_in) begin
         scaled_out <= next_scaled;
         int_out    <= (next_scaled <= low_limit) ||
                       (next_scaled > high_limit);
      end
   end

   // Checks
   sequence s_cmd(logic [4:0] a);
      wr_valid_in && wr_first_in && wr_data_in == {3'h4, a};
   endsequence

   sequence s_data;
      wr_valid_in && !wr_first_in;
   endsequence

   a_gain_common: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_cmd(GPA_OFS_GAIN) ##1 s_data) |=> ##1
      gain_sel_out == $past(wr_data_in[5:4], 2))
      else $error("gain select not taken from written byte");

   a_gain_factor: assert property (@(posedge clk_in) disable iff (rst_in)
      gain_factor_out == (7'h01 << {$past(gain_reg[5:4]), 1'b0}))
      else $error("gain factor wrong for code");

   a_prescale_div: assert property (@(posedge clk_in) disable iff (rst_in)
      conv_done_in |=> scaled_out ==
      (pick($past(count_in), $past(source_reg[1:0])) >>
       $past(gain_reg[2:0])))
      else $error("scaled value not shifted count");

   a_low_alert: assert property (@(posedge clk_in) disable iff (rst_in)
      conv_done_in && next_scaled <= low_limit |=> int_out)
      else $error("no alert at or below low limit");

   a_high_alert: assert property (@(posedge clk_in) disable iff (rst_in)
      conv_done_in && next_scaled > high_limit |=> int_out)
      else $error("no alert above high limit");

   a_in_range: assert property (@(posedge clk_in) disable iff (rst_in)
      conv_done_in && next_scaled > low_limit &&
      next_scaled <= high_limit |=> !int_out)
      else $error("alert while inside limits");

   a_hold_between: assert property (@(posedge clk_in) disable iff (rst_in)
      !conv_done_in |=> $stable(int_out) && $stable(scaled_out))
      else $error("compare result moved without conversion");

   a_low_word: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_cmd(GPA_OFS_LOW_LOWER) ##1 s_data ##1 s_data) |=>
      low_limit == {$past(wr_data_in), $past(wr_data_in, 2)})
      else $error("low limit word not assembled");

   a_high_word: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_cmd(GPA_OFS_HIGH_LOWER) ##1 s_data ##1 s_data) |=>
      high_limit == {$past(wr_data_in), $past(wr_data_in, 2)})
      else $error("high limit word not assembled");

   a_cmd_pointer: assert property (@(posedge clk_in) disable iff (rst_in)
      cmd_wr |=> ptr == $past(wr_data_in[4:0]) &&
      $stable(low_limit) && $stable(high_limit))
      else $error("command byte not stored as pointer");

   a_limit_reset: assert property (@(posedge clk_in)
      rst_in |=> low_limit == 16'h0000 && high_limit == 16'h0000)
      else $error("limits not cleared by reset");
endmodule

/* gpa_core_tb.sv */
// Self-checking bench for the gain, prescaler and limit block
`timescale 1ns/100ps
module gpa_core_tb;
   import gpa_pkg::*;
   logic        clk_in, rst_in, wr_valid, wr_first, rd_req, rd_valid;
   logic        conv_done, int_o;
   logic [7:0]  wr_data, rd_data, b;
   logic [1:0]  gain_sel;
   logic [6:0]  gain_factor;
   logic [15:0] scaled;
   gpa_counts_t cnt;
   int          miscompares, check_count;
   gpa_core DUT (.clk_in(clk_in), .rst_in(rst_in), .wr_valid_in(wr_valid),
      .wr_first_in(wr_first), .wr_data_in(wr_data), .rd_req_in(rd_req),
      .rd_data_out(rd_data), .rd_valid_out(rd_valid), .count_in(cnt),
      .conv_done_in(conv_done), .gain_sel_out(gain_sel),
      .gain_factor_out(gain_factor), .scaled_out(scaled), .int_out(int_o));
   gpa_host u_host (.clk_in(clk_in), .wr_valid_out(wr_valid),
      .wr_first_out(wr_first), .wr_data_out(wr_data), .rd_req_out(rd_req),
      .rd_data_in(rd_data), .rd_valid_in(rd_valid));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic chk(input string n, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conv(input logic [15:0] v, input logic [1:0] s);
      @(negedge clk_in);
      cnt = {4{~v}};
      cnt[s*16 +: 16] = v;
      conv_done = 1'b1;
      @(negedge clk_in);
      conv_done = 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_reset();
      chk("gain_sel", 16'h0000, gain_sel);
      chk("gain_factor", 16'h0001, gain_factor);
      chk("int", 16'h0000, int_o);
      u_host.cmd(8'h87);
      for (int i = 0; i < 5; i++) begin
         u_host.read_byte(b);
         chk("reset reg", 16'h0000, b);
      end
      $display("reset test done");
   endtask
   task automatic t_gain();
      for (int g = 0; g < 4; g++) begin
         u_host.set_gain(g[1:0], 3'h0);
         @(negedge clk_in);
         chk("gain_sel", 16'(g), gain_sel);
         chk("gain_factor", 16'h0001 << (2 * g), gain_factor);
         u_host.cmd(8'h87);
         u_host.read_byte(b);
         chk("gain reg", {2'h0, g[1:0], 4'h0}, b);
      end
      $display("gain test done");
   endtask
   task automatic t_presc();
      u_host.set_source(2'h0);
      u_host.write_word(8'h8a, 8'hff, 8'hff);
      for (int p = 0; p < 7; p++) begin
         u_host.set_gain(2'h3, p[2:0]);
         conv(16'hfedc, 2'h0);
         chk("scaled", 16'hfedc >> p, scaled);
         chk("int", 16'h0000, int_o);
      end
      $display("prescaler test done");
   endtask
   task automatic t_limits();
      logic [15:0] v[4] = '{16'h1234, 16'h1235, 16'h5678, 16'h5679};
      logic        e[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      u_host.write_word(8'h88, 8'h34, 8'h12);
      u_host.write_word(8'h8a, 8'h78, 8'h56);
      u_host.cmd(8'h88);
      u_host.read_byte(b);
      chk("low lower", 16'h0034, b);
      u_host.read_byte(b);
      chk("low upper", 16'h0012, b);
      u_host.read_byte(b);
      chk("high lower", 16'h0078, b);
      u_host.read_byte(b);
      chk("high upper", 16'h0056, b);
      u_host.set_gain(2'h0, 3'h0);
      for (int s = 0; s < 4; s++) begin
         u_host.set_source(s[1:0]);
         for (int i = 0; i < 4; i++) begin
            conv(v[i], s[1:0]);
            chk("scaled", v[i], scaled);
            chk("int", e[i], int_o);
         end
      end
      $display("limit test done");
   endtask
   task automatic t_cmd();
      u_host.put(1'b1, 8'h8a);
      u_host.put(1'b1, 8'h0b);
      u_host.put(1'b0, 8'hee);
      u_host.idle();
      u_host.cmd(8'h8a);
      u_host.read_byte(b);
      chk("high lower", 16'h0078, b);
      u_host.read_byte(b);
      chk("high upper", 16'h0056, b);
      u_host.cmd(8'h8b);
      u_host.read_byte(b);
      chk("high upper", 16'h0056, b);
      $display("command test done");
   endtask
   task automatic t_rerst();
      u_host.set_gain(2'h2, 3'h0);
      @(negedge clk_in);
      rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      chk("int", 16'h0000, int_o);
      chk("scaled", 16'h0000, scaled);
      chk("gain_sel", 16'h0000, gain_sel);
      chk("gain_factor", 16'h0001, gain_factor);
      u_host.cmd(8'h88);
      for (int i = 0; i < 4; i++) begin
         u_host.read_byte(b);
         chk("limit after reset", 16'h0000, b);
      end
      $display("mid-run reset test done");
   endtask
   initial begin
      miscompares = 0;
      check_count = 0;
      rst_in = 1'b1;
      conv_done = 1'b0;
      cnt = '0;
      repeat (6) @(negedge clk_in);
      rst_in = 1'b0;
      t_reset();
      t_gain();
      t_presc();
      t_limits();
      t_cmd();
      t_rerst();
      give_verdict();
   end
   initial begin
      #1000000;
      miscompares++;
      give_verdict();
   end
endmodule

/* gpa_host.sv */
// Host model driving the register write and read port
`timescale 1ns/100ps
module gpa_host (
   input  wire logic       clk_in,
   output logic            wr_valid_out,
   output logic            wr_first_out,
   output logic [7:0]      wr_data_out,
   output logic            rd_req_out,
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in
);
   initial begin
      wr_valid_out = 1'b0;
      wr_first_out = 1'b0;
      wr_data_out  = 8'h00;
      rd_req_out   = 1'b0;
   end
   // One byte for one clock; bytes of a transfer go back to back
   task automatic put(input logic first, input logic [7:0] b);
      @(negedge clk_in);
      wr_valid_out = 1'b1;
      wr_first_out = first;
      wr_data_out  = b;
   endtask
   // Ends a transfer; idle data shows the inverse of the last byte
   task automatic idle();
      @(negedge clk_in);
      wr_valid_out = 1'b0;
      wr_first_out = 1'b0;
      wr_data_out  = ~wr_data_out;
   endtask
   task automatic cmd(input logic [7:0] c);
      put(1'b1, c);
      idle();
   endtask
   task automatic write_word(input logic [7:0] c, lo, hi);
      put(1'b1, c);
      put(1'b0, lo);
      put(1'b0, hi);
      idle();
   endtask
   task automatic set_gain(input logic [1:0] g, input logic [2:0] p);
      put(1'b1, 8'h87);
      put(1'b0, {2'h0, g, 1'b0, p});
      idle();
   endtask
   task automatic set_source(input logic [1:0] s);
      put(1'b1, 8'h83);
      put(1'b0, {6'h00, s});
      idle();
   endtask
   task automatic read_byte(output logic [7:0] b);
      @(negedge clk_in);
      rd_req_out = 1'b1;
      @(negedge clk_in);
      rd_req_out = 1'b0;
      b = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
   endtask
endmodule

/* gpa_pkg.sv */
// Package: register map, field layout and carriers for gain/limit block
package gpa_pkg;
   localparam logic [4:0] GPA_OFS_INT_SOURCE = 5'h03;
   localparam logic [4:0] GPA_OFS_GAIN       = 5'h07;
   localparam logic [4:0] GPA_OFS_LOW_LOWER  = 5'h08;
   localparam logic [4:0] GPA_OFS_LOW_UPPER  = 5'h09;
   localparam logic [4:0] GPA_OFS_HIGH_LOWER = 5'h0a;
   localparam logic [4:0] GPA_OFS_HIGH_UPPER = 5'h0b;

   localparam int GPA_CMD_BIT      = 7;
   localparam int GPA_ADDR_MSB     = 4;
   localparam int GPA_GAIN_MSB     = 5;
   localparam int GPA_GAIN_LSB     = 4;
   localparam int GPA_PRESCALE_MSB = 2;
   localparam int GPA_SOURCE_MSB   = 1;

   localparam logic [7:0] GPA_GAIN_MASK   = 8'h37;
   localparam logic [7:0] GPA_SOURCE_MASK = 8'h03;

   localparam logic [7:0] GPA_RST_GAIN   = 8'h00;
   localparam logic [7:0] GPA_RST_LIMIT  = 8'h00;
   localparam logic [7:0] GPA_RST_SOURCE = 8'h00;
   localparam logic [4:0] GPA_RST_PTR    = 5'h00;

   // Gain codes and relative factors
   localparam logic [1:0] GPA_GAIN_1X  = 2'h0;
   localparam logic [1:0] GPA_GAIN_4X  = 2'h1;
   localparam logic [1:0] GPA_GAIN_16X = 2'h2;
   localparam logic [6:0] GPA_FACTOR_1  = 7'h01;
   localparam logic [6:0] GPA_FACTOR_4  = 7'h04;
   localparam logic [6:0] GPA_FACTOR_16 = 7'h10;
   localparam logic [6:0] GPA_FACTOR_64 = 7'h40;

   // Channel selection codes
   localparam logic [1:0] GPA_SRC_GREEN = 2'h0;
   localparam logic [1:0] GPA_SRC_RED   = 2'h1;
   localparam logic [1:0] GPA_SRC_BLUE  = 2'h2;

   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } gpa_limit_t;

   typedef struct packed {
      logic [15:0] clear;
      logic [15:0] blue;
      logic [15:0] red;
      logic [15:0] green;
   } gpa_counts_t;

   typedef enum logic [1:0] {
      GPA_ST_IDLE = 2'b01,
      GPA_ST_DATA = 2'b10
   } gpa_wr_state_t;
endpackage
